// ==== bench/cpu_bus_model.sv ====
// Purpose: Processor side of the 8-bit timer bus, as tasks.
// Assumes: Requests change on falling edges and span one rising edge.
// Notes: Idle address and data show the inverse of the last access.
`timescale 1ns/10ps
module cpu_bus_model
  import timer16_pkg::*;
(
  input wire logic core_clk,
  output timer16_pkg::bus_req_t busReq,
  input wire logic [7:0] rdData
);
  // Idle bus until the first request
  initial busReq = '0;

  // One access; read data is taken on the falling edge after the strobe edge
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge core_clk);
    busReq = '{rdStb: !wr, wrStb: wr, addr: a, wrData: d};
    @(negedge core_clk);
    q = rdData;
    busReq = '{rdStb: 1'b0, wrStb: 1'b0, addr: ~a, wrData: ~d};
  endtask : access

  // High byte first, the low byte commits both
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    logic [7:0] q;
    access(1'b1, lo + 3'h1, v[15:8], q);
    access(1'b1, lo, v[7:0], q);
  endtask : wr16

  // Low byte first so the holder catches the upper half
  task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
    access(1'b0, lo, 8'h00, v[7:0]);
    access(1'b0, lo + 3'h1, 8'h00, v[15:8]);
  endtask : rd16
endmodule : cpu_bus_model

// ==== bench/timer16_count_and_capture_tb_top.sv ====
// Purpose: Self-checking bench for the count and capture timer.
// Assumes: Inputs change on falling edges; counter stopped unless rate is measured.
// Notes: Random values from a fixed-seed xorshift.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errCount++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module timer16_count_and_capture_tb_top;
  import timer16_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1;
  logic [2:0] clockSelect = 3'h0;
  logic [1:0] modeUpper = 2'h0, modeLower = 2'h0;
  logic noiseFilterEnable = 1'b0, edgeRising = 1'b1, comparatorCaptureSelect = 1'b0;
  logic captureIrqEnable = 1'b0, captureIrqAck = 1'b0, captureFlagClear = 1'b0;
  logic overflowFlagClear = 1'b0, externalClockPin = 1'b0, capturePin = 1'b0;
  logic comparatorOutput = 1'b0;
  logic [7:0] prescaleTicks = 8'h00, rdData;
  logic [15:0] countValue, captureValue;
  logic [15:0] cmpA = 16'h0000; // TOP source in compare-TOP modes
  logic captureFlag, overflowFlag, captureIrq;
  bus_req_t busReq;
  count_stat_t countStat;
  int errCount = 0, comparisons = 0;
  logic [31:0] seed = 32'h0000_0049; // Xorshift state

  // 200 MHz system clock
  always #2.5 core_clk = ~core_clk;

  cpu_bus_model bus (.core_clk(core_clk), .busReq(busReq), .rdData(rdData));

  timer16_count_and_capture dut (.core_clk(core_clk), .srst(srst), .clkEn(1'b1),
    .busReq(busReq), .rdData(rdData), .clockSelect(clockSelect), .modeUpper(modeUpper),
    .modeLower(modeLower), .noiseFilterEnable(noiseFilterEnable), .edgeRising(edgeRising),
    .comparatorCaptureSelect(comparatorCaptureSelect), .captureIrqEnable(captureIrqEnable),
    .captureIrqAck(captureIrqAck), .captureFlagClear(captureFlagClear),
    .overflowFlagClear(overflowFlagClear), .prescaleTicks(prescaleTicks),
    .externalClockPin(externalClockPin), .capturePin(capturePin),
    .comparatorOutput(comparatorOutput), .compareValueA(cmpA),
    .countValue(countValue), .captureValue(captureValue), .countStat(countStat),
    .captureFlag(captureFlag), .overflowFlag(overflowFlag), .captureIrq(captureIrq));

  // Fixed-seed pseudo random word
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd

  // Count expected after n ticks, wrapping at 16 bits
  function automatic logic [15:0] expAfter(input logic [15:0] s, input int n);
    return s + 16'(n);
  endfunction : expAfter

  // One-cycle strobe on a control input
  task automatic strobe(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : strobe

  // One tick from the source that clock select cs names
  task automatic tick(input int cs);
    @(negedge core_clk);
    if (cs < 6) prescaleTicks[cs-2] = 1'b1;
    else externalClockPin = 1'b1;
    @(negedge core_clk);
    prescaleTicks = 8'h00;
    @(negedge core_clk);
    externalClockPin = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : tick

  // Verdict and end of run
  task automatic closeOut();
    if (errCount == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : closeOut

  // Watchdog well beyond the expected run length
  initial
  begin
    #(20000 * 5);
    errCount++;
    closeOut();
  end

  // Main sequence
  initial
  begin
    logic [15:0] v, r, a;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    `CHK(countValue, COUNT_RESET)
    `CHK(countStat.atBottom, 1'b1)
    // Stopped counter: write, hold, read back
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      bus.wr16(ADDR_COUNT_LO, v);
      `CHK(countValue, v)
      repeat (3) @(negedge core_clk);
      bus.rd16(ADDR_COUNT_LO, r);
      `CHK(r, v)
    end
    // Running on every clock; a write wins over the count
    bus.wr16(ADDR_COUNT_LO, rnd() & 16'h7fff);
    clockSelect = 3'h1;
    repeat (2) @(negedge core_clk);
    a = countValue;
    repeat (10) @(negedge core_clk);
    `CHK(countValue, expAfter(a, 10))
    v = rnd() & 16'h7fff;
    bus.wr16(ADDR_COUNT_LO, v);
    `CHK(countValue, v)
    `CHK(overflowFlag, 1'b0)
    bus.wr16(ADDR_COUNT_LO, 16'hfffd);
    repeat (8) @(negedge core_clk);
    `CHK(overflowFlag, 1'b1)
    clockSelect = 3'h0;
    strobe(overflowFlagClear);
    `CHK(overflowFlag, 1'b0)
    // Fixed 8-bit TOP in mode 5, not in mode 0
    {modeUpper, modeLower} = 4'h5;
    bus.wr16(ADDR_COUNT_LO, TOP_8BIT);
    `CHK(countStat.atTop, 1'b1)
    {modeUpper, modeLower} = 4'h0;
    repeat (2) @(negedge core_clk);
    `CHK(countStat.atTop, 1'b0)
    // Each prescaled and external source
    for (int cs = 2; cs < 8; cs++)
    begin
      bus.wr16(ADDR_COUNT_LO, 16'h0000);
      clockSelect = 3'(cs);
      repeat (3) tick(cs);
      repeat (4) @(negedge core_clk);
      clockSelect = 3'h0;
      `CHK(countValue, expAfter(16'h0000, 3))
    end
    // Rising capture, interrupt, acknowledge
    v = rnd();
    bus.wr16(ADDR_COUNT_LO, v);
    captureIrqEnable = 1'b1;
    capturePin = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(captureValue, v)
    `CHK(captureFlag, 1'b1)
    `CHK(captureIrq, 1'b1)
    strobe(captureIrqAck);
    `CHK(captureFlag, 1'b0)
    // Falling capture and byte-wise read; flag alone must not interrupt
    edgeRising = 1'b0;
    captureIrqEnable = 1'b0;
    v = rnd();
    bus.wr16(ADDR_COUNT_LO, v);
    capturePin = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK(captureValue, v)
    `CHK(captureIrq, 1'b0)
    bus.rd16(ADDR_CAPT_LO, r);
    `CHK(r, v)
    strobe(captureFlagClear);
    `CHK(captureFlag, 1'b0)
    // Comparator as source
    edgeRising = 1'b1;
    comparatorCaptureSelect = 1'b1;
    v = rnd();
    bus.wr16(ADDR_COUNT_LO, v);
    strobe(captureFlagClear);
    comparatorOutput = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(captureValue, v)
    // Filter: a short glitch is dropped, a steady level is late
    comparatorCaptureSelect = 1'b0;
    noiseFilterEnable = 1'b1;
    repeat (6) @(negedge core_clk);
    strobe(captureFlagClear);
    capturePin = 1'b1;
    repeat (3) @(negedge core_clk);
    capturePin = 1'b0;
    repeat (8) @(negedge core_clk);
    `CHK(captureFlag, 1'b0)
    capturePin = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(captureFlag, 1'b0)
    repeat (5) @(negedge core_clk);
    `CHK(captureFlag, 1'b1)
    // Capture writes refused in mode 0, taken in mode 12
    noiseFilterEnable = 1'b0;
    bus.wr16(ADDR_CAPT_LO, ~v);
    `CHK(captureValue, v)
    {modeUpper, modeLower} = 4'hc;
    bus.wr16(ADDR_CAPT_LO, ~v);
    `CHK(captureValue, ~v)
    strobe(captureFlagClear);
    capturePin = 1'b0;
    repeat (3) @(negedge core_clk);
    capturePin = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(captureFlag, 1'b0)
    `CHK(captureValue, ~v)
    // Count read leaves its upper byte for a capture low write
    bus.rd16(ADDR_COUNT_LO, r);
    bus.access(1'b1, ADDR_CAPT_LO, 8'h3c, a[7:0]);
    `CHK(captureValue, {v[15:8], 8'h3c})
    // Mode 4 takes TOP from the compare value
    cmpA = rnd();
    {modeUpper, modeLower} = 4'h4;
    bus.wr16(ADDR_COUNT_LO, cmpA);
    `CHK(countStat.atTop, 1'b1)
    // Phase-correct 8-bit: turn at TOP, overflow at BOTTOM
    {modeUpper, modeLower} = 4'h1;
    bus.wr16(ADDR_COUNT_LO, 16'h00fd);
    clockSelect = 3'h1;
    repeat (4) @(negedge core_clk);
    `CHK(countValue, 16'h00fd)
    `CHK(countStat.countingDown, 1'b1)
    `CHK(overflowFlag, 1'b0)
    bus.wr16(ADDR_COUNT_LO, 16'h0002);
    repeat (3) @(negedge core_clk);
    `CHK(overflowFlag, 1'b1)
    `CHK(countStat.countingDown, 1'b0)
    // Capture event in single-slope mode restarts the count
    clockSelect = 3'h0;
    {modeUpper, modeLower} = 4'h0;
    capturePin = 1'b0;
    bus.wr16(ADDR_COUNT_LO, 16'h4000);
    clockSelect = 3'h1;
    capturePin = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(countValue, 16'h0000)
    `CHK(captureValue, 16'h4001)
    clockSelect = 3'h0;
    closeOut();
  end
endmodule : timer16_count_and_capture_tb_top

// ==== verilog/capture_filter.sv ====
// Purpose: Four-sample noise filter in front of the capture edge detector.
// Assumes: Input already synchronous to core_clk.
// Notes: Bypassed when disabled; output still registered for one cycle.
`timescale 1ns/10ps
module capture_filter #(
  parameter int TAPS = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic filterEn,
  input wire logic rawIn,
  output logic filtOut
);
  import timer16_pkg::*;

  // Fewer than two taps leaves no window to agree on
  if (TAPS < 2)
  begin : g_taps_check
    $error("capture_filter needs at least two taps");
  end

  logic [TAPS-1:0] shift_r; // Recent samples, newest in bit 0
  logic [TAPS-1:0] shift_nxt;
  logic out_r; // Filtered level
  logic out_nxt;

  // Next sample window and output decision
  always_comb
  begin
    shift_nxt = {shift_r[TAPS-2:0], rawIn};
    out_nxt = out_r;
    if (!filterEn)
      out_nxt = rawIn;
    else if (&shift_r)
      out_nxt = 1'b1; // All four high
    else if (~|shift_r)
      out_nxt = 1'b0; // All four low
  end

  // Register stage; frozen by clock enable
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      shift_r <= '0;
      out_r <= 1'b0;
    end
    else if (clkEn)
    begin
      shift_r <= shift_nxt;
      out_r <= out_nxt;
    end
  end

  assign filtOut = out_r;

  // Output only moves to a level the whole window agreed on
  filter_agree_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && filterEn && $past(clkEn) && $past(filterEn) && out_r != $past(out_r))
    |-> ($past(shift_r) == {TAPS{out_r}}))
    else $error("filter output changed without agreeing samples");

endmodule : capture_filter

// ==== verilog/timer16_count_and_capture.sv ====
// Purpose: 16-bit up/down counter with input capture behind an 8-bit bus.
// Assumes: Prescaler outside; its ticks arrive as one-cycle strobes.
// Notes: No output compare units; compare values only feed mode TOP.
`timescale 1ns/10ps
module timer16_count_and_capture (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire timer16_pkg::bus_req_t busReq,
  output logic [7:0] rdData,
  input wire logic [2:0] clockSelect,
  input wire logic [1:0] modeUpper,
  input wire logic [1:0] modeLower,
  input wire logic noiseFilterEnable,
  input wire logic edgeRising,
  input wire logic comparatorCaptureSelect,
  input wire logic captureIrqEnable,
  input wire logic captureIrqAck,
  input wire logic captureFlagClear,
  input wire logic overflowFlagClear,
  input wire logic [7:0] prescaleTicks,
  input wire logic externalClockPin,
  input wire logic capturePin,
  input wire logic comparatorOutput,
  input wire logic [15:0] compareValueA,
  output logic [15:0] countValue,
  output logic [15:0] captureValue,
  output timer16_pkg::count_stat_t countStat,
  output logic captureFlag,
  output logic overflowFlag,
  output logic captureIrq
);
  import timer16_pkg::*;

  logic [15:0] count_r; // Counter
  logic [15:0] count_nxt;
  logic [15:0] capt_r; // Capture register
  logic [15:0] capt_nxt;
  logic [7:0] hold_r; // Shared high-byte holding register
  logic [7:0] hold_nxt;
  logic [7:0] rd_r; // Read data
  logic [7:0] rd_nxt;
  logic down_r; // Phase-correct direction
  logic down_nxt;
  logic capFlag_r;
  logic capFlag_nxt;
  logic ovfFlag_r;
  logic ovfFlag_nxt;
  logic extPrev_r; // Previous external pin sample
  logic extPrev_nxt;
  logic capPrev_r; // Previous filtered capture level
  logic capPrev_nxt;

  logic [MODE_W-1:0] mode; // Joined waveform mode
  logic [15:0] topVal;
  logic dualSlope;
  logic capIsTop;
  logic tick;
  logic capSrc;
  logic capFilt;
  logic capEvent;
  logic retrigger;
  logic atTop;
  logic atBottom;
  logic cntWrite;
  logic captWrite;

  // Mode field: upper half from control B, lower from control A
  assign mode = {modeUpper, modeLower};

  // TOP value and mode class decode
  always_comb
  begin
    topVal = MAX_VALUE;
    dualSlope = 1'b0;
    capIsTop = 1'b0;
    unique case (mode)
      4'h1, 4'h5: topVal = TOP_8BIT;
      4'h2, 4'h6: topVal = TOP_9BIT;
      4'h3, 4'h7: topVal = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: topVal = compareValueA;
      4'h8, 4'ha, 4'hc, 4'he:
      begin
        topVal = capt_r;
        capIsTop = 1'b1;
      end
      default: topVal = MAX_VALUE;
    endcase
    // Phase-correct modes run up then down
    dualSlope = (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
  end

  // Timer tick selection; zero selects nothing and stops the counter
  always_comb
  begin
    tick = 1'b0;
    unique case (clockSelect)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1; // Undivided system clock
      3'h2: tick = prescaleTicks[0];
      3'h3: tick = prescaleTicks[1];
      3'h4: tick = prescaleTicks[2];
      3'h5: tick = prescaleTicks[3];
      3'h6: tick = extPrev_r & ~externalClockPin; // Falling edge
      3'h7: tick = ~extPrev_r & externalClockPin; // Rising edge
    endcase
  end

  // Capture source; pin level includes software driving its port
  assign capSrc = comparatorCaptureSelect ? comparatorOutput : capturePin;

  capture_filter #(
    .TAPS(FILTER_TAPS)
  ) u_filter (
    .core_clk(core_clk),
    .srst(srst),
    .clkEn(clkEn),
    .filterEn(noiseFilterEnable),
    .rawIn(capSrc),
    .filtOut(capFilt)
  );

  // Edge detector, disabled while capture register defines TOP
  assign capEvent = !capIsTop && (edgeRising ? (capFilt & ~capPrev_r)
                                             : (~capFilt & capPrev_r));
  // Capture event forces the TOP action
  assign retrigger = capEvent;

  assign atTop = (count_r == topVal);
  assign atBottom = (count_r == COUNT_RESET);

  assign cntWrite = busReq.wrStb && busReq.addr == ADDR_COUNT_LO;
  assign captWrite = busReq.wrStb && busReq.addr == ADDR_CAPT_LO && capIsTop;

  // Counter, direction and overflow flag
  always_comb
  begin
    count_nxt = count_r;
    down_nxt = down_r;
    ovfFlag_nxt = ovfFlag_r & ~overflowFlagClear;
    if (tick)
    begin
      if (dualSlope)
      begin
        if (down_r && atBottom)
        begin
          down_nxt = 1'b0;
          count_nxt = count_r + 16'h0001;
          ovfFlag_nxt = 1'b1; // Overflow at BOTTOM
        end
        else if (!down_r && (atTop || retrigger))
        begin
          down_nxt = 1'b1;
          count_nxt = count_r - 16'h0001;
        end
        else
          count_nxt = down_r ? count_r - 16'h0001 : count_r + 16'h0001;
      end
      else if (atTop || retrigger)
      begin
        count_nxt = COUNT_RESET; // Clear at TOP
        if (mode == 4'h0 || mode == 4'h4 || mode == 4'hc || atTop && count_r == MAX_VALUE
            || mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf})
          ovfFlag_nxt = 1'b1;
      end
      else
        count_nxt = count_r + 16'h0001;
    end
    if (cntWrite)
      count_nxt = {hold_r, busReq.wrData}; // Write wins
  end

  // Capture register, flag and shared holding register
  always_comb
  begin
    capt_nxt = capt_r;
    hold_nxt = hold_r;
    capPrev_nxt = capFilt;
    extPrev_nxt = externalClockPin;
    capFlag_nxt = capFlag_r & ~(captureFlagClear | captureIrqAck);
    if (capEvent)
    begin
      capt_nxt = count_r;
      capFlag_nxt = 1'b1; // Set beats clear
    end
    if (captWrite)
      capt_nxt = {hold_r, busReq.wrData};
    if (busReq.wrStb && (busReq.addr == ADDR_COUNT_HI || busReq.addr == ADDR_CAPT_HI))
      hold_nxt = busReq.wrData; // One holder for all
    if (busReq.rdStb && busReq.addr == ADDR_COUNT_LO)
      hold_nxt = count_r[15:8];
    if (busReq.rdStb && busReq.addr == ADDR_CAPT_LO)
      hold_nxt = capt_r[15:8];
  end

  // Read data mux; upper locations return the holding register
  always_comb
  begin
    rd_nxt = rd_r;
    if (busReq.rdStb)
    begin
      unique case (busReq.addr)
        ADDR_COUNT_LO: rd_nxt = count_r[7:0];
        ADDR_CAPT_LO: rd_nxt = capt_r[7:0];
        ADDR_COUNT_HI, ADDR_CAPT_HI: rd_nxt = hold_r;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  // State registers, frozen while clock enable is low
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      count_r <= COUNT_RESET;
      capt_r <= CAPT_RESET;
      hold_r <= HOLD_RESET;
      rd_r <= 8'h00;
      down_r <= 1'b0;
      capFlag_r <= 1'b0;
      ovfFlag_r <= 1'b0;
      extPrev_r <= 1'b0;
      capPrev_r <= 1'b0;
    end
    else if (clkEn)
    begin
      count_r <= count_nxt;
      capt_r <= capt_nxt;
      hold_r <= hold_nxt;
      rd_r <= rd_nxt;
      down_r <= down_nxt;
      capFlag_r <= capFlag_nxt;
      ovfFlag_r <= ovfFlag_nxt;
      extPrev_r <= extPrev_nxt;
      capPrev_r <= capPrev_nxt;
    end
  end

  assign rdData = rd_r;
  assign countValue = count_r;
  assign captureValue = capt_r;
  assign countStat = '{atTop: atTop, atBottom: atBottom, countingDown: down_r};
  assign captureFlag = capFlag_r;
  assign overflowFlag = ovfFlag_r;
  assign captureIrq = capFlag_r & captureIrqEnable;

  // No tick, no write: counter holds
  stop_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && clockSelect == 3'h0 && !cntWrite) |=> $stable(count_r))
    else $error("counter moved with clock stopped");

  // Write value lands regardless of tick
  write_wins_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && cntWrite) |=> (count_r == {$past(hold_r), $past(busReq.wrData)}))
    else $error("counter write lost");

  // Low read latches upper count byte
  low_read_latch_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && busReq.rdStb && busReq.addr == ADDR_COUNT_LO && !busReq.wrStb)
    |=> (hold_r == $past(count_r[15:8])))
    else $error("holding register not loaded by low read");

  // Capture copies count and raises flag together
  capture_copy_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && capEvent && !captWrite) |=> (capt_r == $past(count_r)) && capFlag_r)
    else $error("capture copy or flag missing");

  // Capture-TOP modes: no pin event touches register or flag
  capture_off_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && capIsTop && !captWrite) |=> ($stable(capt_r) && !$rose(capFlag_r)))
    else $error("capture in capture-top mode");

  // Capture writes ignored outside capture-TOP modes
  capt_guard_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && !capIsTop && !capEvent) |=> $stable(capt_r))
    else $error("capture register changed illegally");

  // Acknowledge drops flag and interrupt unless a capture lands
  irq_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && captureIrqAck && !capEvent) |=> (!capFlag_r && !captureIrq))
    else $error("capture interrupt not cleared by acknowledge");

  // Single-slope tick at TOP clears counter
  top_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && tick && !dualSlope && atTop && !cntWrite) |=> (count_r == 16'h0000))
    else $error("counter did not clear at top");

  // Capture event in single-slope mode restarts the count
  retrig_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && tick && !dualSlope && retrigger && !cntWrite) |=> (count_r == COUNT_RESET))
    else $error("retrigger did not restart the count");

  // Dual-slope turn at BOTTOM raises overflow
  bottom_ovf_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && tick && dualSlope && down_r && atBottom) |=> ovfFlag_r)
    else $error("overflow missing at bottom");

  // Upper-byte writes land in the shared holder
  holder_write_a: assert property (@(posedge core_clk) disable iff (srst)
    (clkEn && busReq.wrStb && (busReq.addr == ADDR_COUNT_HI || busReq.addr == ADDR_CAPT_HI))
    |=> (hold_r == $past(busReq.wrData)))
    else $error("holding register missed an upper write");

endmodule : timer16_count_and_capture

// ==== verilog/timer16_pkg.sv ====
// Purpose: Shared constants and carrier types for the 16-bit count and capture timer.
// Assumes: 8-bit processor I/O bus with one-cycle read and write strobes.
// Notes on behaviour
// - Clock select zero stops the counter
// - Counter counts by one, either direction, or clears
// - TOP and BOTTOM indications from current count
// - Retrigger request performs the TOP action
// - Upper-byte location accesses shared holding register
// - Low read latches upper; low write loads upper
// - Each timer tick clears, increments or decrements by mode
// - Processor write beats count and clear
// - Counter readable and writable without a tick
// - Four-bit waveform mode split across control A and B
// - Overflow flag set at mode-defined point
// - Selected edge copies count into capture register
// - Capture flag set in the copy cycle
// - Capture flag cleared by interrupt or write one
// - Capture low read latches upper into holding register
// - Capture register writable only in capture-TOP modes
// - Comparator select may capture; software clears flag
// - Noise filter adds four system clock delay
// - Filter output changes after four equal samples
// - Capture input disabled in capture-TOP modes
// - Driving the pin port output triggers capture
// - One holding register shared by all 16-bit registers
package timer16_pkg;

  // I/O locations seen by the processor
  localparam logic [2:0] ADDR_COUNT_LO = 3'h0;
  localparam logic [2:0] ADDR_COUNT_HI = 3'h1;
  localparam logic [2:0] ADDR_CAPT_LO = 3'h2;
  localparam logic [2:0] ADDR_CAPT_HI = 3'h3;

  // Field layout
  localparam int CLK_SEL_W = 3;
  localparam int MODE_W = 4;
  localparam int FILTER_TAPS = 4;

  // Reset values and count maximum
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CAPT_RESET = 16'h0000;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [15:0] MAX_VALUE = 16'hffff;

  // Fixed TOP values
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // Processor bus access
  typedef struct packed {
    logic rdStb;
    logic wrStb;
    logic [2:0] addr;
    logic [7:0] wrData;
  } bus_req_t;

  // Counter unit indications
  typedef struct packed {
    logic atTop;
    logic atBottom;
    logic countingDown;
  } count_stat_t;

endpackage : timer16_pkg
